// File: design/mph_pkg.sv
// package: sfr addresses, field positions, reset values, timing counts
package mph_pkg;
	// ************************************************************
	// sfr direct addresses
	// ************************************************************
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_HUB_CONFIGURATION = 8'hC0;
	localparam logic [7:0] ADDR_FUNCTION_COUNT = 8'hC1;
	localparam logic [7:0] ADDR_STATUS_WORD = 8'hD0;
	localparam logic [7:0] ADDR_WATCHDOG_KEY = 8'hFE;
	localparam logic [7:0] ADDR_WATCHDOG_TIMER = 8'hFF;
	localparam logic [7:0] WATCHDOG_KEY_STOP = 8'h55;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int PC_WLE = 4;
	localparam int PC_GF1 = 3;
	localparam int PC_GF0 = 2;
	localparam int PC_PD = 1;
	localparam int PC_IDL = 0;
	localparam int HC_SELF_POWERED = 7;
	localparam int HC_EMU_CLK = 6;
	localparam int HC_MATRIX_OFF = 5;
	localparam int HC_EEPROM_SEL = 4;
	localparam int HC_OC_ENABLE = 3;
	localparam int HC_DIGITAL_OC = 2;
	localparam int HC_PULLUP_OFF = 1;
	localparam int HC_SUSPEND_CLK = 0;
	localparam int PSW_BANK_HI = 4;
	localparam int PSW_BANK_LO = 3;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
	localparam logic [7:0] RST_HUB_CONFIGURATION = 8'h7E;
	localparam logic [7:0] RST_FUNCTION_COUNT = 8'h01;
	localparam logic [7:0] RST_STATUS_WORD = 8'h00;
	localparam logic [7:0] PC_WRITE_MASK = 8'h1F;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 125_000_000;
	localparam int SUSPEND_GATE_US = 2000;
	localparam int SUSPEND_LATE_US = 1000;
	localparam int SUSPEND_GATE_CYC = SUSPEND_GATE_US * (CLK_HZ / 1_000_000);
	localparam int SUSPEND_LATE_CYC = SUSPEND_LATE_US * (CLK_HZ / 1_000_000);
	localparam int EMU_HALF_US_X1000 = 41667;
	localparam int EMU_DIV = 5;
	localparam logic [4:0] BANK_STRIDE = 5'h08;
endpackage

// File: design/mph_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module mph_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// first stage read only by the second stage
	logic [WIDTH-1:0] meta_q;
	// ************************************************************
	// two flops
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// File: design/mph_delay_timer.sv
// down counter that fires one pulse after a loaded number of cycles
`timescale 1ns/1ps
module mph_delay_timer #(
	parameter int CW = 19
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// control
	input wire logic load,
	input wire logic [CW-1:0] load_val,
	input wire logic cancel,
	// status
	output logic busy,
	output logic fire
);
	logic [CW-1:0] cnt_q; // cycles remaining
	// ************************************************************
	// counter; load wins over cancel so a restart is never lost
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			busy <= 1'b0;
			fire <= 1'b0;
		end else if (load) begin
			cnt_q <= load_val;
			busy <= 1'b1;
			fire <= 1'b0;
		end else if (cancel) begin
			busy <= 1'b0;
			fire <= 1'b0;
		end else if (busy && cnt_q <= CW'(1)) begin
			busy <= 1'b0;
			fire <= 1'b1;
		end else begin
			cnt_q <= busy ? cnt_q - CW'(1) : cnt_q;
			fire <= 1'b0;
		end
	end
endmodule

// File: design/mph_regs.sv
// power control and hub configuration special-function registers
// ************************************************************
// ************************************************************
`timescale 1ns/1ps
module mph_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// direct sfr access from the core
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_rvalid,
	// core events
	input wire logic wake_event,
	input wire logic interrupt_taken,
	input wire logic suspend_irq,
	input wire logic in_suspend_handler,
	input wire logic resume_pin,
	// watchdog side
	output logic watchdog_write_en,
	output logic watchdog_running,
	output logic [7:0] watchdog_load_value,
	output logic watchdog_load,
	// clock control
	output logic power_down_active,
	output logic idle_active,
	output logic core_clock_gated,
	output logic emulation_clock_out,
	// register bank
	output logic [4:0] bank_base_addr,
	// hub configuration outputs
	output logic self_powered,
	output logic matrix_pullup_sel,
	output logic eeprom_select_mode,
	output logic overcurrent_detect_enable,
	output logic digital_oc_sense,
	output logic analog_oc_sense,
	output logic upstream_dplus_pullup_en,
	output logic [1:0] function_count_field,
	output logic function_count_valid
);
	import mph_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0] power_control_q; // readable power control
	logic [7:0] hub_configuration_q; // write-only config
	logic [7:0] embedded_function_count_q; // write-only count
	logic [7:0] status_word_q; // stores all eight bits; only bank bits decoded
	logic wd_started_q; // watchdog has been started
	logic wd_stopped_q; // key write halted it
	logic [2:0] emu_div_q; // emulation clock divider
	logic emu_clk_q; // divided clock toggle
	logic gated_q; // suspend gate applied
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic wake_s; // synchronised resume pin
	logic susp_fire; // timer expired
	logic susp_busy;

	// ************************************************************
	// decode
	// ************************************************************
	wire wr_pc = sfr_wr && sfr_addr == ADDR_POWER_CONTROL;
	wire wr_hc = sfr_wr && sfr_addr == ADDR_HUB_CONFIGURATION;
	wire wr_fc = sfr_wr && sfr_addr == ADDR_FUNCTION_COUNT;
	wire wr_sw = sfr_wr && sfr_addr == ADDR_STATUS_WORD;
	wire wr_key = sfr_wr && sfr_addr == ADDR_WATCHDOG_KEY;
	wire wr_wdt = sfr_wr && sfr_addr == ADDR_WATCHDOG_TIMER;
	// only bits 4..0 of power control store; 7..5 read zero
	wire [7:0] pc_wval = sfr_wdata & PC_WRITE_MASK;
	wire watchdog_load_enable = power_control_q[PC_WLE];
	// any wake source: interrupt, resume pin or core wake
	wire wake_any = wake_event || interrupt_taken || wake_s;
	// suspend bit 0 to 1 inside the handler
	wire susp_late_set = wr_hc && in_suspend_handler &&
		!hub_configuration_q[HC_SUSPEND_CLK] &&
		sfr_wdata[HC_SUSPEND_CLK];
	wire susp_early = suspend_irq && hub_configuration_q[HC_SUSPEND_CLK];
	wire susp_cancel = wake_any ||
		(wr_hc && !sfr_wdata[HC_SUSPEND_CLK]);
	wire [18:0] susp_val = susp_late_set ?
		19'(SUSPEND_LATE_CYC) : 19'(SUSPEND_GATE_CYC);
	wire [1:0] bank_sel = {status_word_q[PSW_BANK_HI],
		status_word_q[PSW_BANK_LO]};

	// bank number to first address of its eight registers
	function automatic logic [4:0] bank_base(input logic [1:0] b);
		bank_base = 5'(b) * BANK_STRIDE;
	endfunction

	// read mux: configs are write-only and read as zero
	function automatic logic [7:0] rd_mux(input logic [7:0] a,
		input logic [7:0] pc, input logic [7:0] sw);
		if (a == ADDR_POWER_CONTROL) begin
			rd_mux = pc;
		end else if (a == ADDR_STATUS_WORD) begin
			rd_mux = sw;
		end else begin
			rd_mux = 8'h00;
		end
	endfunction

	// ************************************************************
	// resume pin synchroniser
	// ************************************************************
	mph_sync #(.WIDTH(1)) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.async_in(resume_pin),
		.sync_out(wake_s)
	);

	// ************************************************************
	// suspend clock gating delay
	// ************************************************************
	mph_delay_timer #(.CW(19)) u_susp (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.load(susp_early || susp_late_set),
		.load_val(susp_val),
		.cancel(susp_cancel),
		.busy(susp_busy),
		.fire(susp_fire)
	);

	// ************************************************************
	// power control
	// ************************************************************
	// wake clears the mode bits; a same-cycle write still lands
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			power_control_q <= RST_POWER_CONTROL;
		end else if (wr_pc) begin
			power_control_q <= pc_wval;
		end else if (wake_any) begin
			power_control_q[PC_PD] <= 1'b0;
			power_control_q[PC_IDL] <= 1'b0;
		end
	end

	// ************************************************************
	// hub configuration and function count
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hub_configuration_q <= RST_HUB_CONFIGURATION;
			embedded_function_count_q <= RST_FUNCTION_COUNT;
		end else begin
			if (wr_hc) begin
				hub_configuration_q <= sfr_wdata;
			end
			if (wr_fc) begin
				embedded_function_count_q <= sfr_wdata;
			end
		end
	end

	// ************************************************************
	// status word bank bits
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			status_word_q <= RST_STATUS_WORD;
		end else if (wr_sw) begin
			status_word_q <= sfr_wdata;
		end
	end

	// ************************************************************
	// watchdog start and stop
	// ************************************************************
	// start on first enable; only the key or reset stops it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wd_started_q <= 1'b0;
			wd_stopped_q <= 1'b0;
		end else begin
			if (wr_pc && pc_wval[PC_WLE]) begin
				wd_started_q <= 1'b1;
			end
			if (wr_key && sfr_wdata == WATCHDOG_KEY_STOP) begin
				wd_stopped_q <= 1'b1;
			end
		end
	end

	// ************************************************************
	// watchdog outputs
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			watchdog_write_en <= 1'b0;
			watchdog_running <= 1'b0;
			watchdog_load <= 1'b0;
			watchdog_load_value <= 8'h00;
		end else begin
			watchdog_write_en <= watchdog_load_enable;
			watchdog_running <= wd_started_q && !wd_stopped_q;
			watchdog_load <= wr_wdt && watchdog_load_enable;
			watchdog_load_value <= wr_wdt && watchdog_load_enable ? sfr_wdata :
				watchdog_load_value;
		end
	end

	// ************************************************************
	// suspend gate state
	// ************************************************************
	// clock stays gated until a wake; bit at 0 never gates
	// expiry and wake in one cycle: expiry wins and the gate is set;
	// that wake is ignored, so an expiry is never lost
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gated_q <= 1'b0;
		end else if (susp_fire) begin
			gated_q <= 1'b1;
		end else if (wake_any) begin
			gated_q <= 1'b0;
		end
	end

	// ************************************************************
	// emulation clock divider
	// ************************************************************
	// 125 MHz cannot divide to exactly 12 MHz; nearest even
	// divide gives 12.5 MHz, which suits emulation probes
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			emu_div_q <= 3'h0;
			emu_clk_q <= 1'b0;
		end else if (!hub_configuration_q[HC_EMU_CLK]) begin
			emu_div_q <= 3'h0;
			emu_clk_q <= 1'b0;
		end else if (emu_div_q == 3'(EMU_DIV - 1)) begin
			emu_div_q <= 3'h0;
			emu_clk_q <= !emu_clk_q;
		end else begin
			emu_div_q <= emu_div_q + 3'h1;
		end
	end

	// ************************************************************
	// registered outputs
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			power_down_active <= 1'b0;
			idle_active <= 1'b0;
			core_clock_gated <= 1'b0;
			emulation_clock_out <= 1'b0;
			bank_base_addr <= 5'h00;
		end else begin
			power_down_active <= power_control_q[PC_PD];
			idle_active <= power_control_q[PC_IDL];
			core_clock_gated <= gated_q || power_control_q[PC_PD];
			emulation_clock_out <= emu_clk_q;
			bank_base_addr <= bank_base(bank_sel);
		end
	end

	// ************************************************************
	// hub configuration outputs
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			self_powered <= 1'b0;
			matrix_pullup_sel <= 1'b1;
			eeprom_select_mode <= 1'b1;
			overcurrent_detect_enable <= 1'b1;
			digital_oc_sense <= 1'b1;
			analog_oc_sense <= 1'b0;
			upstream_dplus_pullup_en <= 1'b0;
			function_count_field <= 2'h1;
			function_count_valid <= 1'b1;
		end else begin
			self_powered <= hub_configuration_q[HC_SELF_POWERED];
			matrix_pullup_sel <= hub_configuration_q[HC_MATRIX_OFF];
			eeprom_select_mode <= hub_configuration_q[HC_EEPROM_SEL];
			overcurrent_detect_enable <=
				hub_configuration_q[HC_OC_ENABLE];
			digital_oc_sense <= hub_configuration_q[HC_OC_ENABLE] &&
				hub_configuration_q[HC_DIGITAL_OC];
			analog_oc_sense <= hub_configuration_q[HC_OC_ENABLE] &&
				!hub_configuration_q[HC_DIGITAL_OC];
			upstream_dplus_pullup_en <=
				!hub_configuration_q[HC_PULLUP_OFF];
			function_count_field <= embedded_function_count_q[1:0];
			function_count_valid <=
				embedded_function_count_q[1:0] != 2'h0;
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= sfr_rd ? rd_mux(sfr_addr, power_control_q,
				status_word_q) : 8'h00;
			rvalid_q <= sfr_rd;
		end
	end
	assign sfr_rdata = rdata_q;
	assign sfr_rvalid = rvalid_q;
endmodule

// File: testbench/mph_regs_sva.sv
// checker: timing relations at the sfr register block ports
`timescale 1ns/1ps
module mph_regs_sva
	import mph_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// sfr access
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_rvalid,
	// events and status
	input wire logic wake_event,
	input wire logic interrupt_taken,
	input wire logic watchdog_write_en,
	input wire logic watchdog_running,
	input wire logic watchdog_load,
	input wire logic power_down_active,
	input wire logic idle_active,
	input wire logic [4:0] bank_base_addr,
	input wire logic overcurrent_detect_enable,
	input wire logic digital_oc_sense,
	input wire logic analog_oc_sense,
	input wire logic [1:0] function_count_field,
	input wire logic function_count_valid
);
	// ************************************************************
	// write decodes
	// ************************************************************
	wire wr_pc = sfr_wr && (sfr_addr == ADDR_POWER_CONTROL); // power write
	wire wr_ff = sfr_wr && (sfr_addr == ADDR_WATCHDOG_TIMER); // timer write
	wire wr_en1 = wr_pc && sfr_wdata[PC_WLE]; // load enable set
	wire key55 = sfr_wr && (sfr_addr == ADDR_WATCHDOG_KEY)
		&& (sfr_wdata == WATCHDOG_KEY_STOP); // stop key
	wire rd_wo = sfr_rd && (sfr_addr == ADDR_HUB_CONFIGURATION
		|| sfr_addr == ADDR_FUNCTION_COUNT); // write-only read

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	chk_read_valid: assert property (sfr_rd |=> sfr_rvalid)
		else $error("read strobe gave no valid pulse");
	chk_rdata_quiet: assert property (!sfr_rvalid |-> sfr_rdata == 8'h00)
		else $error("read data not zero outside a read");
	chk_wo_zero: assert property (rd_wo |=> sfr_rdata == 8'h00)
		else $error("write-only register read back nonzero");
	chk_pc_reserved: assert property (sfr_rd && sfr_addr == ADDR_POWER_CONTROL
		|=> sfr_rdata[7:5] == 3'h0)
		else $error("reserved power bits read nonzero");
	chk_wdog_block: assert property (wr_ff && !watchdog_write_en
		&& !$past(wr_pc) && !$past(wr_pc, 2)
		|=> !watchdog_load ##1 !watchdog_load)
		else $error("timer write taken while load disabled");
	chk_wdog_start: assert property ($rose(watchdog_running)
		|-> $past(wr_en1) || $past(wr_en1, 2) || $past(wr_en1, 3))
		else $error("watchdog started without load enable");
	chk_wdog_stop: assert property ($fell(watchdog_running)
		|-> $past(key55) || $past(key55, 2) || $past(key55, 3))
		else $error("watchdog stopped without key");
	chk_bank_align: assert property (bank_base_addr[2:0] == 3'h0)
		else $error("bank base not on eight byte boundary");
	chk_oc_sense: assert property ((digital_oc_sense || analog_oc_sense)
		|-> overcurrent_detect_enable
		&& !(digital_oc_sense && analog_oc_sense))
		else $error("overcurrent sense mode inconsistent");
	chk_count_valid: assert property (function_count_valid
		== (function_count_field != 2'h0))
		else $error("function count valid flag wrong");
	chk_idle_clear: assert property (interrupt_taken && !wr_pc
		|=> ##1 !idle_active)
		else $error("idle not cleared by interrupt");
	chk_wake_clear: assert property (wake_event && !wr_pc
		|=> ##1 !power_down_active)
		else $error("power-down not cleared by wake");
endmodule

// File: testbench/mcu_power_and_hub_config_regs_tb.sv
// testbench: register rows, watchdog, wake, suspend and reset cases
`timescale 1ns/1ps
module mcu_power_and_hub_config_regs_tb;
	import mph_pkg::*;
	// ************************************************************
	// signals and table
	// ************************************************************
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] r;
	} mph_row_s;
	logic core_clk = 1'b0, arst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, got;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rvalid, wake_event = 1'b0;
	logic interrupt_taken = 1'b0, suspend_irq = 1'b0, resume_pin = 1'b0;
	logic in_suspend_handler = 1'b0, watchdog_write_en, watchdog_running;
	logic [7:0] watchdog_load_value;
	logic watchdog_load, power_down_active, idle_active, core_clock_gated;
	logic emulation_clock_out, self_powered, matrix_pullup_sel;
	logic eeprom_select_mode, overcurrent_detect_enable, digital_oc_sense;
	logic analog_oc_sense, upstream_dplus_pullup_en, function_count_valid;
	logic [4:0] bank_base_addr;
	logic [1:0] function_count_field;
	int err_count = 0, n_checks = 0;
	// address, write data, expected read back
	mph_row_s rows [21] = '{
		'{8'h87, 8'h0F, 8'h0F}, '{8'h87, 8'hE3, 8'h03}, '{8'h87, 8'h0C, 8'h0C},
		'{8'h87, 8'h00, 8'h00}, '{8'hD0, 8'h00, 8'h00}, '{8'hD0, 8'h08, 8'h08},
		'{8'hD0, 8'h10, 8'h10}, '{8'hD0, 8'hFF, 8'hFF}, '{8'hC0, 8'h80, 8'h00},
		'{8'hC0, 8'h40, 8'h00}, '{8'hC0, 8'h20, 8'h00}, '{8'hC0, 8'h10, 8'h00},
		'{8'hC0, 8'h08, 8'h00}, '{8'hC0, 8'h0C, 8'h00}, '{8'hC0, 8'h02, 8'h00},
		'{8'hC1, 8'h02, 8'h00}, '{8'hC1, 8'h03, 8'h00}, '{8'hC1, 8'h00, 8'h00},
		'{8'hFE, 8'hAA, 8'h00}, '{8'h3A, 8'hFF, 8'h00}, '{8'hD0, 8'h00, 8'h00}};

	always #4 core_clk = ~core_clk; // 125 MHz

	mph_regs dut_u (.core_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata, .sfr_rvalid, .wake_event, .interrupt_taken,
		.suspend_irq, .in_suspend_handler, .resume_pin, .watchdog_write_en,
		.watchdog_running, .watchdog_load_value, .watchdog_load,
		.power_down_active, .idle_active, .core_clock_gated,
		.emulation_clock_out, .bank_base_addr, .self_powered,
		.matrix_pullup_sel, .eeprom_select_mode, .overcurrent_detect_enable,
		.digital_oc_sense, .analog_oc_sense, .upstream_dplus_pullup_en,
		.function_count_field, .function_count_valid);

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one write strobe, returns at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge core_clk);
		sfr_wr <= 1'b0;
	endtask
	// read with bounded wait for the valid pulse
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		int n;
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge core_clk);
		sfr_rd <= 1'b0;
		for (n = 0; n < 4; n++) begin
			#1;
			if (sfr_rvalid === 1'b1) break;
			@(posedge core_clk);
		end
		q = sfr_rdata;
		if (n == 4) begin
			err_count++;
			test_done();
		end
	endtask
	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	// a load pulse seen within the next few cycles
	task automatic saw_load(input logic exp);
		logic s;
		#1 s = watchdog_load;
		repeat (3) begin
			@(posedge core_clk);
			#1 s = s | watchdog_load;
		end
		chk({7'h0, s}, {7'h0, exp});
	endtask
	// hub configuration outputs against the byte written
	task automatic cfg_chk(input logic [7:0] d);
		int t;
		logic p;
		chk({1'b0, self_powered, matrix_pullup_sel, eeprom_select_mode,
			overcurrent_detect_enable, digital_oc_sense, analog_oc_sense,
			upstream_dplus_pullup_en}, {1'b0, d[7], d[5], d[4], d[3],
			d[3] & d[2], d[3] & ~d[2], ~d[1]});
		t = 0;
		p = emulation_clock_out;
		repeat (20) begin
			@(posedge core_clk);
			#1 if (emulation_clock_out !== p) t++;
			p = emulation_clock_out;
		end
		// divided clock toggles every few cycles only when enabled
		chk({7'h0, t > 2}, {7'h0, d[6]});
	endtask
	task automatic rst_chk();
		cfg_chk(RST_HUB_CONFIGURATION);
		chk({5'h0, function_count_valid, function_count_field},
			{5'h0, 1'b1, RST_FUNCTION_COUNT[1:0]});
		chk({3'h0, watchdog_running, bank_base_addr}, 8'h00);
		rd(ADDR_POWER_CONTROL, got);
		chk(got, RST_POWER_CONTROL);
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1 rst_chk();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			settle();
			rd(rows[i].a, got);
			chk(got, rows[i].r);
			if (rows[i].a == ADDR_STATUS_WORD)
				chk({3'h0, bank_base_addr}, {3'h0, rows[i].d[4:3], 3'h0});
			if (rows[i].a == ADDR_HUB_CONFIGURATION) cfg_chk(rows[i].d);
			if (rows[i].a == ADDR_FUNCTION_COUNT)
				chk({6'h0, function_count_field}, {6'h0, rows[i].d[1:0]});
		end
		// watchdog: blocked, started, loaded, wrong key, stop key
		wr(ADDR_WATCHDOG_TIMER, 8'h3C);
		saw_load(1'b0);
		wr(ADDR_POWER_CONTROL, 8'h10);
		settle();
		chk({6'h0, watchdog_write_en, watchdog_running}, 8'h03);
		wr(ADDR_WATCHDOG_TIMER, 8'hA5);
		saw_load(1'b1);
		chk(watchdog_load_value, 8'hA5);
		wr(ADDR_WATCHDOG_KEY, 8'h54);
		settle();
		chk({7'h0, watchdog_running}, 8'h01);
		wr(ADDR_WATCHDOG_KEY, WATCHDOG_KEY_STOP);
		wr(ADDR_POWER_CONTROL, 8'h10);
		settle();
		chk({7'h0, watchdog_running}, 8'h00);
		// idle cleared by interrupt, power-down by wake and by pin
		wr(ADDR_POWER_CONTROL, 8'h11);
		settle();
		chk({7'h0, idle_active}, 8'h01);
		@(posedge core_clk);
		interrupt_taken <= 1'b1;
		@(posedge core_clk);
		interrupt_taken <= 1'b0;
		settle();
		chk({7'h0, idle_active}, 8'h00);
		wr(ADDR_POWER_CONTROL, 8'h12);
		settle();
		chk({6'h0, power_down_active, core_clock_gated}, 8'h03);
		@(posedge core_clk);
		wake_event <= 1'b1;
		@(posedge core_clk);
		wake_event <= 1'b0;
		settle();
		chk({6'h0, power_down_active, core_clock_gated}, 8'h00);
		wr(ADDR_POWER_CONTROL, 8'h13);
		resume_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
		resume_pin <= 1'b0;
		settle();
		rd(ADDR_POWER_CONTROL, got);
		chk(got, 8'h10);
		// suspend with gate bit clear keeps the clock running
		wr(ADDR_HUB_CONFIGURATION, 8'h00);
		in_suspend_handler <= 1'b1;
		suspend_irq <= 1'b1;
		@(posedge core_clk);
		suspend_irq <= 1'b0;
		repeat (20) @(posedge core_clk);
		in_suspend_handler <= 1'b0;
		#1 chk({7'h0, core_clock_gated}, 8'h00);
		// second reset in mid-run restores defaults; watchdog, already stopped by the key, stays off
		wr(ADDR_POWER_CONTROL, 8'h1C);
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1 rst_chk();
		test_done();
	end
	// hang guard
	initial begin
		#800000;
		err_count++;
		test_done();
	end
endmodule

bind mph_regs mph_regs_sva chk_u (.core_clk, .arst_n, .sfr_addr, .sfr_wr,
	.sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_rvalid, .wake_event,
	.interrupt_taken, .watchdog_write_en, .watchdog_running, .watchdog_load,
	.power_down_active, .idle_active, .bank_base_addr,
	.overcurrent_detect_enable, .digital_oc_sense, .analog_oc_sense,
	.function_count_field, .function_count_valid);
